// ### rtl/rgf_status_regs.sv
// rail good-status and sticky fault register pair on the host register port
`timescale 1ns/100ps
module rgf_status_regs (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	// live in-regulation indications, high while in window
	input wire logic fixed_five_volt_good_i,
	input wire logic adj_reg_one_good_i,
	input wire logic termination_reg_good_i,
	input wire logic switch_b_two_good_i,
	input wire logic switch_b_one_good_i,
	input wire logic adj_reg_three_good_i,
	// loss-of-regulation indications, high while out of window
	input wire logic adj_reg_two_fault_i,
	input wire logic switch_a_one_fault_i,
	input wire logic step_down_six_fault_i,
	input wire logic step_down_five_fault_i,
	input wire logic step_down_four_fault_i,
	input wire logic step_down_three_fault_i,
	input wire logic step_down_two_fault_i,
	input wire logic step_down_one_fault_i,
	// host register port
	input wire logic [rgf_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [rgf_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [rgf_pkg::DATA_W-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// register images for the rest of the device
	output logic [rgf_pkg::DATA_W-1:0] rail_good_status_second_o,
	output logic [rgf_pkg::DATA_W-1:0] rail_fault_status_first_o
);
	// whole-bank state apart from the fault flags
	typedef struct packed {
		logic [rgf_pkg::DATA_W-1:0] good; // sampled good-status image
		logic [rgf_pkg::DATA_W-1:0] rdata; // read answer
		logic rvalid; // read answer strobe
		logic armed; // one enabled edge seen out of reset
	} rgf_top_s;

	rgf_top_s st_q; // registered state
	rgf_top_s st_d; // next state
	logic rst_n; // synchronised reset
	logic [rgf_pkg::DATA_W-1:0] good_now; // live good vector
	logic [rgf_pkg::DATA_W-1:0] fault_evt; // live fault vector
	logic [rgf_pkg::DATA_W-1:0] fault_clr; // write-one-to-clear mask
	logic [rgf_pkg::DATA_W-1:0] fault_q; // sticky flags
	logic [rgf_pkg::DATA_W-1:0] rd_mux; // selected read word
	logic fault_wr; // write hits the fault register

	// reset release through two flops
	rgf_reset_sync u_rst (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.clk_en_i(clk_en_i),
		.rst_sync_n_o(rst_n)
	);

	// gather the good indications into register order
	always_comb begin
		good_now = rgf_pkg::GOOD_RESET; // reserved bits stay zero
		good_now[rgf_pkg::GB_FIXED_FIVE] = fixed_five_volt_good_i; // RULE2
		good_now[rgf_pkg::GB_ADJ_ONE] = adj_reg_one_good_i; // RULE3
		good_now[rgf_pkg::GB_TERM] = termination_reg_good_i; // RULE4
		good_now[rgf_pkg::GB_SW_B_TWO] = switch_b_two_good_i; // RULE5
		good_now[rgf_pkg::GB_SW_B_ONE] = switch_b_one_good_i; // RULE6
		good_now[rgf_pkg::GB_ADJ_THREE] = adj_reg_three_good_i; // RULE7
	end

	// gather the fault indications into register order
	always_comb begin
		fault_evt = '0;
		fault_evt[rgf_pkg::FB_ADJ_TWO] = adj_reg_two_fault_i; // RULE10
		fault_evt[rgf_pkg::FB_SW_A_ONE] = switch_a_one_fault_i; // RULE11
		fault_evt[rgf_pkg::FB_STEP_SIX] = step_down_six_fault_i; // RULE12
		fault_evt[rgf_pkg::FB_STEP_FIVE] = step_down_five_fault_i; // RULE13
		fault_evt[rgf_pkg::FB_STEP_FOUR] = step_down_four_fault_i; // RULE14
		fault_evt[rgf_pkg::FB_STEP_THREE] = step_down_three_fault_i; // RULE15
		fault_evt[rgf_pkg::FB_STEP_TWO] = step_down_two_fault_i; // RULE16
		fault_evt[rgf_pkg::FB_STEP_ONE] = step_down_one_fault_i; // RULE17
	end

	// writes only reach the fault register; good-status ignores them
	assign fault_wr = reg_wr_i && (reg_addr_i == rgf_pkg::FAULT_ADDR); // RULE20
	assign fault_clr = fault_wr ? reg_wdata_i : '0; // RULE18

	// sticky flags; a fault level keeps re-setting its flag
	rgf_sticky_flags #(
		.WIDTH(rgf_pkg::FAULT_RAILS),
		.RESET_VAL(rgf_pkg::FAULT_RESET)
	) u_flags (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n),
		.clk_en_i(clk_en_i),
		.set_i(fault_evt),
		.clr_i(fault_clr),
		.flags_o(fault_q)
	);

	// read decode; values are those before this cycle's update
	always_comb begin
		case (reg_addr_i)
			rgf_pkg::GOOD_ADDR: begin
				rd_mux = st_q.good; // RULE8
			end
			rgf_pkg::FAULT_ADDR: begin
				rd_mux = fault_q; // RULE9
			end
			default: begin
				rd_mux = rgf_pkg::UNMAPPED_READ; // other offsets belong elsewhere
			end
		endcase
	end

	// next state; everything holds while the clock enable is low
	always_comb begin
		st_d = st_q;
		if (clk_en_i) begin
			// one-cycle sampling keeps the image glitch-free for reads
			st_d.good = good_now; // RULE1
			st_d.rvalid = reg_rd_i;
			st_d.armed = 1'b1; // state has now left reset once
			if (reg_rd_i) begin
				st_d.rdata = rd_mux;
			end
		end
	end

	// state register
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_q.good <= rgf_pkg::GOOD_RESET; // RULE8
			st_q.rdata <= '0;
			st_q.rvalid <= 1'b0;
			st_q.armed <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rail_good_status_second_o = st_q.good;
	assign rail_fault_status_first_o = fault_q;
	assign reg_rdata_o = st_q.rdata;
	assign reg_rvalid_o = st_q.rvalid;

	// checks; helper terms only feed assertions
	logic [rgf_pkg::DATA_W-1:0] kept_flags; // flags no write tries to clear
	logic [rgf_pkg::DATA_W-1:0] race_bits; // clear and event together
	logic [rgf_pkg::DATA_W-1:0] quiet_clr; // clearing ones on quiet rails
	logic [rgf_pkg::DATA_W-1:0] idle_bits; // flag low and rail quiet
	assign kept_flags = fault_q & ~fault_clr;
	assign race_bits = fault_clr & fault_evt;
	assign quiet_clr = fault_clr & ~fault_evt;
	assign idle_bits = ~fault_q & ~fault_evt;

	default clocking cb @(posedge mclk_i);
	endclocking
	// the edge that ends the internal reset still loads reset values, so checks wait one enabled edge more
	default disable iff (!st_q.armed);

	chk_good_whole_vec: assert property (clk_en_i |=> rail_good_status_second_o == $past(good_now)) // RULE1
		else $error("good-status image does not follow the rails");
	chk_good_five_bit: assert property (clk_en_i |=> rail_good_status_second_o[5] == $past(fixed_five_volt_good_i)) // RULE2
		else $error("bit 5 does not follow the fixed five-volt rail");
	chk_good_adj_one: assert property (clk_en_i |=> rail_good_status_second_o[4] == $past(adj_reg_one_good_i)) // RULE3
		else $error("bit 4 does not follow adjustable regulator one");
	chk_good_term_bit: assert property (clk_en_i |=> rail_good_status_second_o[3] == $past(termination_reg_good_i)) // RULE4
		else $error("bit 3 does not follow the termination regulator");
	chk_good_swb_two: assert property (clk_en_i |=> rail_good_status_second_o[2] == $past(switch_b_two_good_i)) // RULE5
		else $error("bit 2 does not follow switch B two");
	chk_good_swb_one: assert property (clk_en_i |=> rail_good_status_second_o[1] == $past(switch_b_one_good_i)) // RULE6
		else $error("bit 1 does not follow switch B one");
	chk_good_adj_three: assert property (clk_en_i |=> rail_good_status_second_o[0] == $past(adj_reg_three_good_i)) // RULE7
		else $error("bit 0 does not follow adjustable regulator three");
	chk_good_reset_zero: assert property (@(posedge mclk_i) disable iff (1'b0) !rst_n |-> rail_good_status_second_o == 8'h00) // RULE8
		else $error("good-status not zero in reset");
	chk_fault_reset_zero: assert property (@(posedge mclk_i) disable iff (1'b0) !rst_n |-> rail_fault_status_first_o == 8'h00) // RULE9
		else $error("fault register not zero in reset");
	chk_fault_adj_two: assert property (clk_en_i && adj_reg_two_fault_i |=> rail_fault_status_first_o[7]) // RULE10
		else $error("bit 7 not set by adjustable regulator two fault");
	chk_fault_swa_one: assert property (clk_en_i && switch_a_one_fault_i |=> rail_fault_status_first_o[6]) // RULE11
		else $error("bit 6 not set by switch A one fault");
	chk_fault_step_six: assert property (clk_en_i && step_down_six_fault_i |=> rail_fault_status_first_o[5]) // RULE12
		else $error("bit 5 not set by step-down six fault");
	chk_fault_step_five: assert property (clk_en_i && step_down_five_fault_i |=> rail_fault_status_first_o[4]) // RULE13
		else $error("bit 4 not set by step-down five fault");
	chk_fault_step_four: assert property (clk_en_i && step_down_four_fault_i |=> rail_fault_status_first_o[3]) // RULE14
		else $error("bit 3 not set by step-down four fault");
	chk_fault_step_three: assert property (clk_en_i && step_down_three_fault_i |=> rail_fault_status_first_o[2]) // RULE15
		else $error("bit 2 not set by step-down three fault");
	chk_fault_step_two: assert property (clk_en_i && step_down_two_fault_i |=> rail_fault_status_first_o[1]) // RULE16
		else $error("bit 1 not set by step-down two fault");
	chk_fault_step_one: assert property (clk_en_i && step_down_one_fault_i |=> rail_fault_status_first_o[0]) // RULE17
		else $error("bit 0 not set by step-down one fault");
	chk_clear_drops_flag: assert property (clk_en_i && fault_wr |=>
		(rail_fault_status_first_o & $past(reg_wdata_i & ~fault_evt)) == 8'h00) // RULE18
		else $error("written one did not clear a quiet flag");
	chk_zero_write_keeps: assert property (clk_en_i |=>
		(rail_fault_status_first_o & $past(kept_flags)) == $past(kept_flags)) // RULE18
		else $error("flag lost without a clearing one");
	chk_set_beats_clear: assert property (clk_en_i && race_bits != 8'h00 |=>
		(rail_fault_status_first_o & $past(race_bits)) == $past(race_bits)) // RULE19
		else $error("clear won over a coincident fault");
	// per flag: a set flag with no clearing one stays set
	chk_flag_sticks_on: assert property (kept_flags[rgf_pkg::FB_STEP_ONE] // RULE19
		|=> fault_q[rgf_pkg::FB_STEP_ONE])
		else $error("step-down one flag dropped after rail recovery");
	chk_hold_step_two: assert property (kept_flags[rgf_pkg::FB_STEP_TWO] // RULE19
		|=> fault_q[rgf_pkg::FB_STEP_TWO])
		else $error("step-down two flag dropped after rail recovery");
	chk_hold_step_three: assert property (kept_flags[rgf_pkg::FB_STEP_THREE] // RULE19
		|=> fault_q[rgf_pkg::FB_STEP_THREE])
		else $error("step-down three flag dropped after rail recovery");
	chk_hold_step_four: assert property (kept_flags[rgf_pkg::FB_STEP_FOUR] // RULE19
		|=> fault_q[rgf_pkg::FB_STEP_FOUR])
		else $error("step-down four flag dropped after rail recovery");
	chk_hold_step_five: assert property (kept_flags[rgf_pkg::FB_STEP_FIVE] // RULE19
		|=> fault_q[rgf_pkg::FB_STEP_FIVE])
		else $error("step-down five flag dropped after rail recovery");
	chk_hold_step_six: assert property (kept_flags[rgf_pkg::FB_STEP_SIX] // RULE19
		|=> fault_q[rgf_pkg::FB_STEP_SIX])
		else $error("step-down six flag dropped after rail recovery");
	chk_hold_swa_one: assert property (kept_flags[rgf_pkg::FB_SW_A_ONE] // RULE19
		|=> fault_q[rgf_pkg::FB_SW_A_ONE])
		else $error("switch A one flag dropped after rail recovery");
	chk_hold_adj_two: assert property (kept_flags[rgf_pkg::FB_ADJ_TWO] // RULE19
		|=> fault_q[rgf_pkg::FB_ADJ_TWO])
		else $error("adjustable regulator two flag dropped after rail recovery");
	chk_reserved_zero: assert property (rail_good_status_second_o[7:6] == 2'b00) // RULE20
		else $error("reserved good-status bits not zero");
	chk_read_answer: assert property (clk_en_i && reg_rd_i |=> reg_rvalid_o && reg_rdata_o == $past(rd_mux))
		else $error("read answer wrong or late");
	chk_freeze_hold: assert property (!clk_en_i |=> $stable(rail_fault_status_first_o) && $stable(rail_good_status_second_o))
		else $error("state moved with clock enable low");
	// per flag: a clearing one on a quiet rail drops that flag
	chk_clear_step_one: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_STEP_ONE] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_ONE])
		else $error("step-down one flag survived a clearing one");
	chk_clear_step_two: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_STEP_TWO] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_TWO])
		else $error("step-down two flag survived a clearing one");
	chk_clear_step_three: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_STEP_THREE] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_THREE])
		else $error("step-down three flag survived a clearing one");
	chk_clear_step_four: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_STEP_FOUR] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_FOUR])
		else $error("step-down four flag survived a clearing one");
	chk_clear_step_five: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_STEP_FIVE] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_FIVE])
		else $error("step-down five flag survived a clearing one");
	chk_clear_step_six: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_STEP_SIX] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_SIX])
		else $error("step-down six flag survived a clearing one");
	chk_clear_swa_one: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_SW_A_ONE] // RULE18
		|=> !fault_q[rgf_pkg::FB_SW_A_ONE])
		else $error("switch A one flag survived a clearing one");
	chk_clear_adj_two: assert property (clk_en_i && quiet_clr[rgf_pkg::FB_ADJ_TWO] // RULE18
		|=> !fault_q[rgf_pkg::FB_ADJ_TWO])
		else $error("adjustable regulator two flag survived a clearing one");
	// per flag: no fault on the rail means no flag appears
	chk_quiet_step_one: assert property (idle_bits[rgf_pkg::FB_STEP_ONE] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_ONE])
		else $error("step-down one flag set with no fault");
	chk_quiet_step_two: assert property (idle_bits[rgf_pkg::FB_STEP_TWO] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_TWO])
		else $error("step-down two flag set with no fault");
	chk_quiet_step_three: assert property (idle_bits[rgf_pkg::FB_STEP_THREE] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_THREE])
		else $error("step-down three flag set with no fault");
	chk_quiet_step_four: assert property (idle_bits[rgf_pkg::FB_STEP_FOUR] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_FOUR])
		else $error("step-down four flag set with no fault");
	chk_quiet_step_five: assert property (idle_bits[rgf_pkg::FB_STEP_FIVE] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_FIVE])
		else $error("step-down five flag set with no fault");
	chk_quiet_step_six: assert property (idle_bits[rgf_pkg::FB_STEP_SIX] // RULE18
		|=> !fault_q[rgf_pkg::FB_STEP_SIX])
		else $error("step-down six flag set with no fault");
	chk_quiet_swa_one: assert property (idle_bits[rgf_pkg::FB_SW_A_ONE] // RULE18
		|=> !fault_q[rgf_pkg::FB_SW_A_ONE])
		else $error("switch A one flag set with no fault");
	chk_quiet_adj_two: assert property (idle_bits[rgf_pkg::FB_ADJ_TWO] // RULE18
		|=> !fault_q[rgf_pkg::FB_ADJ_TWO])
		else $error("adjustable regulator two flag set with no fault");
	// read answers per offset, against the images the host would see
	chk_read_good_reg: assert property (clk_en_i && reg_rd_i && reg_addr_i == rgf_pkg::GOOD_ADDR // RULE8
		|=> reg_rdata_o == $past(rail_good_status_second_o))
		else $error("good-status read returned another word");
	chk_read_fault_reg: assert property (clk_en_i && reg_rd_i && reg_addr_i == rgf_pkg::FAULT_ADDR // RULE9
		|=> reg_rdata_o == $past(rail_fault_status_first_o))
		else $error("fault read returned another word");
	chk_read_unmapped: assert property (clk_en_i && reg_rd_i && reg_addr_i != rgf_pkg::GOOD_ADDR
		&& reg_addr_i != rgf_pkg::FAULT_ADDR |=> reg_rdata_o == rgf_pkg::UNMAPPED_READ)
		else $error("unmapped read returned a nonzero word");
	chk_rvalid_pulse: assert property (clk_en_i && !reg_rd_i |=> !reg_rvalid_o)
		else $error("read answer strobe without a read");

	cov_clear_race: cover property (clk_en_i && race_bits != 8'h00);
	cov_fault_read: cover property (clk_en_i && reg_rd_i && reg_addr_i == rgf_pkg::FAULT_ADDR && fault_q != 8'h00);
	cov_clear_done: cover property (clk_en_i && fault_wr && (fault_q & reg_wdata_i) != 8'h00 ##1 fault_q == 8'h00);
	cov_all_good: cover property (rail_good_status_second_o == 8'h3f);
endmodule

// ### include/rgf_pkg.sv
// constants shared by the rail good and fault status register bank
// What this block does
// (RULE1) good bit is 1 while rail regulates
// (RULE2) good bit 5 shows fixed five-volt regulator
// (RULE3) good bit 4 shows adjustable regulator one
// (RULE4) good bit 3 shows termination regulator
// (RULE5) good bit 2 shows group B switch two
// (RULE6) good bit 1 shows group B switch one
// (RULE7) good bit 0 shows adjustable regulator three
// (RULE8) good register at B1h, resets to zero
// (RULE9) fault register at B2h, resets to zero
// (RULE10) fault bit 7 sets on adjustable regulator two
// (RULE11) fault bit 6 sets on group A switch one
// (RULE12) fault bit 5 sets on step-down six
// (RULE13) fault bit 4 sets on step-down five
// (RULE14) fault bit 3 sets on step-down four
// (RULE15) fault bit 2 sets on step-down three
// (RULE16) fault bit 1 sets on step-down two
// (RULE17) fault bit 0 sets on step-down one
// (RULE18) write 1 clears flag, 0 keeps it
// (RULE19) flags stay set; new fault beats clear
// (RULE20) good upper two bits read zero always
package rgf_pkg;
	localparam int unsigned ADDR_W = 8; // register address width
	localparam int unsigned DATA_W = 8; // register data width
	localparam logic [7:0] GOOD_ADDR = 8'hb1; // good-status register offset
	localparam logic [7:0] FAULT_ADDR = 8'hb2; // fault register offset
	localparam logic [7:0] GOOD_RESET = 8'h00; // good-status reset value
	localparam logic [7:0] FAULT_RESET = 8'h00; // fault register reset value
	localparam logic [7:0] UNMAPPED_READ = 8'h00; // answer to unknown offsets
	localparam int unsigned GOOD_RAILS = 6; // live status bits in use
	localparam int unsigned FAULT_RAILS = 8; // sticky fault bits
	// good-status field positions
	localparam int unsigned GB_FIXED_FIVE = 5;
	localparam int unsigned GB_ADJ_ONE = 4;
	localparam int unsigned GB_TERM = 3;
	localparam int unsigned GB_SW_B_TWO = 2;
	localparam int unsigned GB_SW_B_ONE = 1;
	localparam int unsigned GB_ADJ_THREE = 0;
	// fault field positions
	localparam int unsigned FB_ADJ_TWO = 7;
	localparam int unsigned FB_SW_A_ONE = 6;
	localparam int unsigned FB_STEP_SIX = 5;
	localparam int unsigned FB_STEP_FIVE = 4;
	localparam int unsigned FB_STEP_FOUR = 3;
	localparam int unsigned FB_STEP_THREE = 2;
	localparam int unsigned FB_STEP_TWO = 1;
	localparam int unsigned FB_STEP_ONE = 0;
endpackage

// ### rtl/rgf_reset_sync.sv
// reset release synchroniser for the status register bank
`timescale 1ns/100ps
module rgf_reset_sync (
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic clk_en_i,
	output logic rst_sync_n_o
);
	// two-stage shift; only the second stage leaves the module
	typedef struct packed {
		logic stage1;
		logic stage2;
	} rgf_sync_s;

	rgf_sync_s st_q;
	rgf_sync_s st_d;

	// shift a one in after release
	always_comb begin
		st_d = st_q;
		if (clk_en_i) begin
			st_d.stage1 = 1'b1;
			st_d.stage2 = st_q.stage1;
		end
	end

	// assert asynchronously, release on the clock
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rst_sync_n_o = st_q.stage2;
endmodule

// ### rtl/rgf_sticky_flags.sv
// bank of sticky write-one-to-clear flags
`timescale 1ns/100ps
module rgf_sticky_flags #(
	parameter int unsigned WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic clk_en_i,
	input wire logic [WIDTH-1:0] set_i,
	input wire logic [WIDTH-1:0] clr_i,
	output logic [WIDTH-1:0] flags_o
);
	// refuse an empty bank
	if (WIDTH < 1) begin : g_bad_width
		$error("rgf_sticky_flags: WIDTH must be at least 1");
	end

	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} rgf_flag_s;

	rgf_flag_s st_q;
	rgf_flag_s st_d;

	// clear drops only written ones; a set in the same cycle wins
	always_comb begin
		st_d = st_q;
		if (clk_en_i) begin
			st_d.flags = (st_q.flags & ~clr_i) | set_i; // RULE18 RULE19
		end
	end

	// flag storage
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q.flags <= RESET_VAL;
		end else begin
			st_q <= st_d;
		end
	end

	assign flags_o = st_q.flags;
endmodule

// ### verif/rail_good_and_fault_status_tb_top.sv
// self-checking bench for the rail good and fault status register pair
`timescale 1ns/100ps
module rail_good_and_fault_status_tb_top;
	logic mclk_i = 1'b0; // 40 MHz bench clock
	logic resetn_i = 1'b0; // async reset, active low
	logic clk_en_i = 1'b1; // clock enable
	logic [5:0] gd = '0; // live good indications, bit = field position
	logic [7:0] ft = '0; // loss-of-regulation indications
	logic [7:0] addr = '0; // register offset
	logic [7:0] wd = '0; // write data
	logic wr = 1'b0; // write strobe
	logic rd = 1'b0; // read strobe
	logic [7:0] rdata; // read data seen
	logic rv; // read valid seen
	logic [7:0] good; // good image seen
	logic [7:0] fault; // fault image seen
	int err_total = 0; // mismatches
	int num_checks = 0; // comparisons made
	bit chk = 1'b0; // comparisons armed once reset settles
	int unsigned seed = 94664; // xorshift state
	int m_s1 = 0; // model reset synchroniser, first stage
	int m_s2 = 0; // model reset synchroniser, second stage
	int m_good = 0; // model good image
	int m_fault = 0; // model sticky flags
	int m_rdata = 0; // model read data
	int m_rv = 0; // model read valid
	int r = 0; // random word

	// port map written bit by bit, so a swapped field shows as a mismatch
	rgf_status_regs i_rgf_status_regs (
		.mclk_i(mclk_i),
		.resetn_i(resetn_i),
		.clk_en_i(clk_en_i),
		.fixed_five_volt_good_i(gd[5]),
		.adj_reg_one_good_i(gd[4]),
		.termination_reg_good_i(gd[3]),
		.switch_b_two_good_i(gd[2]),
		.switch_b_one_good_i(gd[1]),
		.adj_reg_three_good_i(gd[0]),
		.adj_reg_two_fault_i(ft[7]),
		.switch_a_one_fault_i(ft[6]),
		.step_down_six_fault_i(ft[5]),
		.step_down_five_fault_i(ft[4]),
		.step_down_four_fault_i(ft[3]),
		.step_down_three_fault_i(ft[2]),
		.step_down_two_fault_i(ft[1]),
		.step_down_one_fault_i(ft[0]),
		.reg_addr_i(addr),
		.reg_wr_i(wr),
		.reg_wdata_i(wd),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata),
		.reg_rvalid_o(rv),
		.rail_good_status_second_o(good),
		.rail_fault_status_first_o(fault)
	);

	// free-running clock, 25 ns period
	initial begin
		forever #12.5 mclk_i = ~mclk_i;
	end

	// behavioural model of the register pair, integers only
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			m_s1 = 0;
			m_s2 = 0;
			m_good = 0;
			m_fault = 0;
			m_rdata = 0;
			m_rv = 0;
		end else if (clk_en_i) begin
			if (m_s2 == 0) begin
				// internal reset still held at this edge
				m_good = 0;
				m_fault = 0;
				m_rdata = 0;
				m_rv = 0;
			end else begin
				m_rv = rd;
				// read sees the value from before any same-cycle write
				if (rd) begin
					m_rdata = (addr == 8'hb1) ? m_good : (addr == 8'hb2) ? m_fault : 0;
				end
				m_good = gd;
				// clear by one, then new fault wins
				m_fault = (m_fault & ~((wr && addr == 8'hb2) ? int'(wd) : 0)) | ft;
			end
			m_s2 = m_s1;
			m_s1 = 1;
		end
	end

	function automatic int unsigned xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one cycle: compare settled outputs, then drive the next inputs
	task automatic cyc(input logic [5:0] g, input logic [7:0] f, input logic [7:0] a,
			input logic w, input logic [7:0] d, input logic rr);
		@(negedge mclk_i);
		if (chk) begin
			check(good, 8'(m_good));
			check(fault, 8'(m_fault));
			check(rdata, 8'(m_rdata));
			check({7'h00, rv}, 8'(m_rv));
		end
		gd = g;
		ft = f;
		addr = a;
		wr = w;
		wd = d;
		rd = rr;
	endtask

	task automatic results();
		if (err_total == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// watchdog, far beyond the roughly 480 cycles of the sequence
	initial begin
		#(25 * 5000);
		err_total++;
		results();
	end

	initial begin
		repeat (2) @(negedge mclk_i);
		resetn_i = 1'b1;
		repeat (4) cyc('0, '0, '0, 1'b0, '0, 1'b0);
		chk = 1'b1;
		// reset values of both registers
		cyc('0, '0, 8'hb1, 1'b0, '0, 1'b1);
		cyc('0, '0, 8'hb2, 1'b0, '0, 1'b1);
		// each good bit alone; writes of ones to the read-only register
		for (int i = 0; i < 6; i++) begin
			cyc(6'(1 << i), '0, 8'hb1, 1'b1, 8'hff, 1'b1);
			cyc(6'(1 << i), '0, 8'hb1, 1'b0, '0, 1'b1);
		end
		cyc('0, '0, 8'hb1, 1'b0, '0, 1'b1);
		// each fault bit: one-cycle pulse, write zero, clear, coincident clear
		for (int i = 0; i < 8; i++) begin
			cyc('0, 8'(1 << i), '0, 1'b0, '0, 1'b0);
			cyc('0, '0, 8'hb2, 1'b1, '0, 1'b0);
			cyc('0, '0, 8'hb2, 1'b0, '0, 1'b1);
			cyc('0, '0, 8'hb2, 1'b1, 8'(1 << i), 1'b0);
			cyc('0, 8'(1 << i), 8'hb2, 1'b1, 8'(1 << i), 1'b0);
			cyc('0, '0, 8'hb2, 1'b1, 8'(1 << i), 1'b1);
		end
		// unmapped offsets read zero and take no write
		cyc('0, '0, 8'hb3, 1'b1, 8'hff, 1'b1);
		cyc('0, '0, 8'h00, 1'b0, '0, 1'b1);
		// random traffic with the enable dropping now and then
		repeat (400) begin
			r = int'(xs());
			cyc(r[5:0], r[15:8] & r[23:16], (r[25:24] == 2'd3) ? 8'(xs()) : (r[24] ? 8'hb2 : 8'hb1),
				r[26], 8'(xs()), r[27]);
			clk_en_i = r[28] | r[29] | r[30];
		end
		clk_en_i = 1'b1;
		// mid-run reset with flags set, then resync with rails up
		cyc(6'h3f, 8'hff, '0, 1'b0, '0, 1'b0);
		cyc(6'h3f, '0, '0, 1'b0, '0, 1'b0);
		resetn_i = 1'b0;
		repeat (3) cyc(6'h3f, '0, '0, 1'b0, '0, 1'b0);
		resetn_i = 1'b1;
		repeat (5) cyc(6'h3f, '0, 8'hb2, 1'b0, '0, 1'b1);
		cyc('0, '0, 8'hb1, 1'b0, '0, 1'b1);
		cyc('0, '0, '0, 1'b0, '0, 1'b0);
		results();
	end
endmodule
